// *** rtl/osw_ctrl.sv ***
// Oscillator switch control and status register with APB slave
// Operation
// - Clock-fail flag, bit 3, sets on a detected clock failure, else stays zero.
// - Software reads the clock-fail flag and clears it by writing zero to it; starting a switch also clears it.
// - Bit 1 enables the secondary low-power oscillator while set.
// - Writing one to bit 0 starts a switch to the selected new source.
// - Bit 0 reads zero once the switch has completed.
// - Bit 2 is unused: reads zero, writes ignored.
// - Register writes are accepted only after the unlock sequence.
// - Register resets only on power-on reset; other resets leave it.
// - Request for the already current source clears the bit and aborts.
// - After the new source is ready, wait ten new-clock cycles.
// - Current source takes the new selection as the request bit clears.
// - With switching disabled, the request bit is ignored and held zero.
//
// Decided for this implementation: the APB slave port and the register offsets.
module osw_ctrl
    import osw_pkg::*;
#(
    parameter int unsigned NEW_CLK_WAIT = OSW_NEW_CLK_WAIT
) (
    // Clock, power-on reset and clock enable
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // Oscillator unit side, asynchronous inputs
    input  wire logic                 fail_detect,
    input  wire logic                 src_ready,
    input  wire logic                 new_clk_tick,
    input  wire logic                 switch_allowed,
    // Oscillator unit side, controls and status
    output logic                      secondary_osc_enable,
    output logic [OSW_SRC_W-1:0]      new_source_select,
    output logic [OSW_SRC_W-1:0]      current_source,
    output logic                      switch_request
);
    osw_regs_s r_q;
    osw_regs_s r_d;

    logic        acc;
    logic        setup;
    logic        wr_ctrl;
    logic        wr_unl;
    logic [15:0] ctrl_rd;
    logic        tick_edge;

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[OSW_REQ_BIT]  = r_q.req;
        ctrl_rd[OSW_LPEN_BIT] = r_q.lp_en;
        ctrl_rd[OSW_CF_BIT]   = r_q.cf;
        ctrl_rd[OSW_LOCK_BIT] = r_q.rdy_sy[1];
        ctrl_rd[OSW_NSEL_LSB +: OSW_SRC_W] = r_q.nsel;
        ctrl_rd[OSW_CSEL_LSB +: OSW_SRC_W] = r_q.csel;     // bit 2 stays 0
    end

    always_comb begin
        r_d   = r_q;
        acc   = psel && penable && r_q.pready;
        setup = psel && !penable;
        wr_ctrl = acc && pwrite && (paddr == OSW_CTRL_ADDR);
        wr_unl  = acc && pwrite && (paddr == OSW_UNLOCK_ADDR);
        tick_edge = r_q.tick_sy[1] && !r_q.tick_prev;

        // Only the second flop of each synchroniser feeds logic
        r_d.fail_sy   = {r_q.fail_sy[0], fail_detect};
        r_d.rdy_sy    = {r_q.rdy_sy[0], src_ready};
        r_d.tick_sy   = {r_q.tick_sy[0], new_clk_tick};
        r_d.swen_sy   = {r_q.swen_sy[0], switch_allowed};
        r_d.tick_prev = r_q.tick_sy[1];

        // APB: no wait states, answer registered in the setup cycle
        r_d.pready  = setup;
        r_d.pslverr = 1'b0;
        r_d.prdata  = OSW_WORD_ZERO;
        if (setup) begin
            if (paddr == OSW_CTRL_ADDR) begin
                r_d.prdata[15:0] = ctrl_rd;
            end else if (paddr != OSW_UNLOCK_ADDR) begin
                r_d.pslverr = 1'b1;
            end
        end

        // Two keys back to back open exactly one control write
        if (wr_unl) begin
            r_d.key1_seen = (pwdata[15:0] == OSW_KEY1);
            if (r_q.key1_seen && pwdata[15:0] == OSW_KEY2) begin
                r_d.unlocked = 1'b1;
            end else begin
                r_d.unlocked = 1'b0;
            end
        end else if (acc && pwrite) begin
            r_d.key1_seen = 1'b0;
            r_d.unlocked  = 1'b0;
        end

        if (wr_ctrl && r_q.unlocked) begin
            r_d.lp_en = pwdata[OSW_LPEN_BIT];
            if (!pwdata[OSW_CF_BIT]) begin
                r_d.cf = 1'b0;
            end
            // Selection is frozen while a switch runs to keep the target stable
            if (!r_q.req) begin
                r_d.nsel = pwdata[OSW_NSEL_LSB +: OSW_SRC_W];
                if (pwdata[OSW_REQ_BIT]) begin
                    r_d.req = 1'b1;
                end
            end
        end

        unique case (r_q.st)
            OSW_IDLE: begin
                if (r_q.req) begin
                    if (r_q.nsel == r_q.csel) begin
                        r_d.req = 1'b0;
                    end else begin
                        r_d.cf = 1'b0;
                        r_d.st = OSW_READY;
                    end
                end
            end
            OSW_READY: begin
                r_d.cnt = OSW_CNT_ZERO;
                if (r_q.rdy_sy[1]) begin
                    r_d.st = OSW_COUNT;
                end
            end
            OSW_COUNT: begin
                if (tick_edge) begin
                    r_d.cnt = r_q.cnt + 1'b1;
                    if (r_q.cnt == OSW_CNT_W'(NEW_CLK_WAIT - 1)) begin
                        r_d.st   = OSW_IDLE;
                        r_d.req  = 1'b0;
                        r_d.csel = r_q.nsel;
                    end
                end
            end
            default: begin
                r_d.st = OSW_IDLE;
            end
        endcase

        if (!r_q.swen_sy[1]) begin
            r_d.req = 1'b0;
            r_d.st  = OSW_IDLE;
        end

        // A failure in the same cycle as a clear still sets the flag
        if (r_q.fail_sy[1]) begin
            r_d.cf = 1'b1;
        end
    end

    // Only power-on reset clears this state; no other reset is wired in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{fail_sy:   OSW_SY_RST,
                     rdy_sy:    OSW_SY_RST,
                     tick_sy:   OSW_SY_RST,
                     swen_sy:   OSW_SY_RST,
                     tick_prev: 1'b0,
                     key1_seen: 1'b0,
                     unlocked:  1'b0,
                     req:       1'b0,
                     lp_en:     1'b0,
                     cf:        1'b0,
                     nsel:      OSW_SRC_RST,
                     csel:      OSW_SRC_RST,
                     st:        OSW_IDLE,
                     cnt:       OSW_CNT_ZERO,
                     pready:    1'b0,
                     pslverr:   1'b0,
                     prdata:    OSW_WORD_ZERO};
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign pready               = r_q.pready;
    assign pslverr              = r_q.pslverr;
    assign prdata               = r_q.prdata;
    assign secondary_osc_enable = r_q.lp_en;
    assign new_source_select    = r_q.nsel;
    assign current_source       = r_q.csel;
    assign switch_request       = r_q.req;
endmodule : osw_ctrl

// *** rtl/osw_pkg.sv ***
// Package: register map, field layout and states of the oscillator switch
package osw_pkg;
    localparam logic [11:0] OSW_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] OSW_UNLOCK_ADDR = 12'h004;
    localparam int          OSW_ADDR_W      = 12;
    // Unlock key values are arbitrary
    localparam logic [15:0] OSW_KEY1        = 16'h5AC3;
    localparam logic [15:0] OSW_KEY2        = 16'hC35A;
    localparam int          OSW_REQ_BIT     = 0;
    localparam int          OSW_LPEN_BIT    = 1;
    localparam int          OSW_CF_BIT      = 3;
    localparam int          OSW_LOCK_BIT    = 5;
    localparam int          OSW_NSEL_LSB    = 8;
    localparam int          OSW_CSEL_LSB    = 12;
    localparam int          OSW_SRC_W       = 3;
    localparam int          OSW_CNT_W       = 4;
    localparam int          OSW_NEW_CLK_WAIT = 10;
    localparam logic [2:0]  OSW_SRC_RST     = 3'h0;
    localparam logic [1:0]  OSW_SY_RST      = 2'h0;
    localparam logic [3:0]  OSW_CNT_ZERO    = 4'h0;
    localparam logic [31:0] OSW_WORD_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        OSW_IDLE  = 2'b00,
        OSW_READY = 2'b01,
        OSW_COUNT = 2'b10
    } osw_state_e;

    typedef struct packed {
        logic [1:0]           fail_sy;
        logic [1:0]           rdy_sy;
        logic [1:0]           tick_sy;
        logic [1:0]           swen_sy;
        logic                 tick_prev;
        logic                 key1_seen;
        logic                 unlocked;
        logic                 req;
        logic                 lp_en;
        logic                 cf;
        logic [OSW_SRC_W-1:0] nsel;
        logic [OSW_SRC_W-1:0] csel;
        osw_state_e           st;
        logic [OSW_CNT_W-1:0] cnt;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
    } osw_regs_s;
endpackage : osw_pkg

// *** test/osw_chk.sv ***
// Checker: port-level assertions for the oscillator switch control
module osw_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // Oscillator side
    input wire logic        switch_allowed,
    input wire logic        secondary_osc_enable,
    input wire logic [2:0]  new_source_select,
    input wire logic [2:0]  current_source,
    input wire logic        switch_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd0 = psel && penable && pready && !pwrite && paddr == 12'h000;
    wire wr0 = psel && penable && pready && pwrite && paddr == 12'h000;
    a_bit2_zero: assert property (
        rd0 |-> !prdata[2]) else $error("Unused bit read as one");
    // Answer is registered at setup, so compare with the earlier state
    a_req_read: assert property (
        rd0 |-> prdata[0] == $past(switch_request))
        else $error("Request bit read wrong");
    a_src_update: assert property (
        $changed(current_source) |-> $fell(switch_request))
        else $error("Current source moved without completion");
    a_held_off: assert property (
        !switch_allowed [*4] |=> !switch_request)
        else $error("Request set while switching disabled");
    a_redundant_abort: assert property (
        $rose(switch_request) && new_source_select == current_source
        |-> ##[1:2] !switch_request) else $error("Redundant switch kept");
    a_switch_wait: assert property (
        $rose(switch_request) && new_source_select != current_source
        |=> switch_request [*3]) else $error("Switch finished too early");
    a_lp_write: assert property (
        $changed(secondary_osc_enable) |-> $past(wr0))
        else $error("Enable changed without a write");
    a_req_cause: assert property (
        $rose(switch_request) |-> $past(wr0 && pwdata[0]))
        else $error("Request rose without a write");
    c_switch: cover property ($fell(switch_request) && $changed(current_source));
    c_abort: cover property ($rose(switch_request)
        && new_source_select == current_source);
    c_fail_read: cover property (rd0 && prdata[3]);
endmodule : osw_chk

bind osw_ctrl osw_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .switch_allowed,
    .secondary_osc_enable, .new_source_select, .current_source,
    .switch_request);

// *** test/tb_top.sv ***
// Testbench: register-level tests of the oscillator switch control
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import osw_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        clk_en = 1, fail_detect = 0, src_ready = 0, new_clk_tick = 0;
    logic        switch_allowed = 1, pready, pslverr, lp_en, sw_req;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [2:0]  nsel, csel, pick;
    logic [63:0] notes[$];
    int          error_cnt = 0, checks = 0, seed = 23;
    always #25 pclk = ~pclk;
    osw_ctrl #(.NEW_CLK_WAIT(2)) dut (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .fail_detect, .src_ready, .new_clk_tick, .switch_allowed,
        .secondary_osc_enable(lp_en), .new_source_select(nsel),
        .current_source(csel), .switch_request(sw_req));
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(logic [31:0] exp, logic [31:0] m);
        notes.push_back({m, exp});
        apb(0, OSW_CTRL_ADDR, 0);
    endtask : rd
    // Every control write needs a fresh unlock
    task automatic ulw(logic [31:0] d);
        apb(1, OSW_UNLOCK_ADDR, {16'h0, OSW_KEY1});
        apb(1, OSW_UNLOCK_ADDR, {16'h0, OSW_KEY2});
        apb(1, OSW_CTRL_ADDR, d);
    endtask : ulw
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check("control read", prdata & notes[0][63:32], notes[0][31:0]);
            void'(notes.pop_front());
        end
        if (psel && penable && pready === 1'b1) begin
            check("slave error", 32'(pslverr),
                  32'(paddr != OSW_CTRL_ADDR && paddr != OSW_UNLOCK_ADDR));
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    initial begin
        #200us;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rd(0, 32'hFFFF_FFFF);
        apb(1, 12'h008, 32'h0002);
        apb(1, OSW_CTRL_ADDR, 32'h0002);
        rd(0, 32'h0000_0002);
        ulw(32'h0006);
        rd(32'h0002, 32'h0000_0006);
        @(posedge pclk);
        check("secondary enable", 32'(lp_en), 32'h1);
        $display("register access test done");
        fail_detect <= 1;
        repeat (3) @(posedge pclk);
        fail_detect <= 0;
        rd(32'h0008, 32'h0000_0008);
        rd(32'h0008, 32'h0000_0008);
        ulw(32'h0002);
        rd(32'h0000, 32'h0000_0008);
        $display("clock fail test done");
        pick = 3'({$random(seed)} % 7 + 1);
        src_ready <= 1;
        // Start from the reset source 0, switch to a random source 1 to 7
        ulw({17'h0, 3'h0, 1'b0, pick, 8'h03});
        rd({17'h0, 3'h0, 1'b0, pick, 8'h23}, 32'h0000_7F2F);
        // Slow tick so each edge survives the synchroniser
        repeat (6) begin
            repeat (3) @(posedge pclk);
            new_clk_tick <= ~new_clk_tick;
        end
        repeat (6) @(posedge pclk);
        rd({17'h0, pick, 1'b0, pick, 8'h22}, 32'h0000_7F2F);
        @(posedge pclk);
        check("current source", 32'(csel), 32'(pick));
        check("switch request", 32'(sw_req), 32'h0);
        ulw({17'h0, pick, 1'b0, pick, 8'h03});
        rd({17'h0, pick, 1'b0, pick, 8'h22}, 32'h0000_7F2F);
        $display("switch test done");
        switch_allowed <= 0;
        repeat (4) @(posedge pclk);
        ulw({17'h0, pick, 1'b0, pick + 3'h1, 8'h03});
        rd({17'h0, pick, 12'h000}, 32'h0000_7001);
        switch_allowed <= 1;
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        rd(32'h0020, 32'hFFFF_FFFF);
        $display("disable and reset test done");
        summarize();
    end
endmodule : tb_top
